/* design/rbcd_consts.vh */
// Opcode, field and reset constants for the branch and modify decoder
`ifndef RBCD_CONSTS_VH
`define RBCD_CONSTS_VH

// Opcode high nibble groups
`define RBCD_GRP_BITBR    4'h0
`define RBCD_GRP_BITSC    4'h1
`define RBCD_GRP_BRANCH   4'h2
`define RBCD_GRP_RMW_DIR  4'h3
`define RBCD_GRP_RMW_ACC  4'h4
`define RBCD_GRP_RMW_IDX  4'h5

// Modify sub-operations (opcode low nibble)
`define RBCD_RMW_NEG      4'h0
`define RBCD_RMW_COM      4'h3
`define RBCD_RMW_LSR      4'h4
`define RBCD_RMW_ROR      4'h6
`define RBCD_RMW_ASR      4'h7
`define RBCD_RMW_ASL      4'h8
`define RBCD_RMW_ROL      4'h9
`define RBCD_RMW_DEC      4'hA
`define RBCD_RMW_INC      4'hC
`define RBCD_RMW_TST      4'hD
`define RBCD_RMW_CLR      4'hF

// Control and jump opcodes
`define RBCD_OP_RTS       8'h81
`define RBCD_OP_STOP      8'h8E
`define RBCD_OP_WAIT      8'h8F
`define RBCD_OP_TAX       8'h97
`define RBCD_OP_CLC       8'h98
`define RBCD_OP_SEC       8'h99
`define RBCD_OP_CLI       8'h9A
`define RBCD_OP_SEI       8'h9B
`define RBCD_OP_RSP       8'h9C
`define RBCD_OP_NOP       8'h9D
`define RBCD_OP_TXA       8'h9F
`define RBCD_OP_JMP_DIR   8'hBC
`define RBCD_OP_JSR_DIR   8'hBD
`define RBCD_OP_JMP_EXT   8'hCC
`define RBCD_OP_JSR_EXT   8'hCD

// Condition code bit positions in CCR_O
`define RBCD_CC_C         0
`define RBCD_CC_Z         1
`define RBCD_CC_N         2
`define RBCD_CC_I         3
`define RBCD_CC_H         4

// Reset values
`define RBCD_PC_RST       16'h0000
`define RBCD_SP_RST       8'hFF
`define RBCD_CCR_RST      5'h08
`define RBCD_PAGE0_HI     8'h00

`endif

/* design/rbcd_core.v */
// Decode and execute of modify, branch, bit and control instructions
// What this block does
// - Modify instructions read operand, transform it, write it back same place
// - Negative-or-zero test updates flags only, never writes back
// - False branch condition leaves PC on the next instruction
// - Branch destination is PC plus signed offset byte
// - Bit-test branch is three bytes: opcode, page-zero address, offset
// - Bit number and tested polarity come from the opcode
// - Bit branch reaches -128..+127 from the following instruction
// - Tested bit is copied into carry whether or not branch taken
// - Bit set and clear reach any bit of the lowest 256 bytes
// - Control instructions are inherent with no operand address
// - Jump and jump-to-subroutine use only an address operand
// - Oscillator stop halts oscillator and enables interrupt request pin
// - Wait stops core clock and clears the interrupt mask
// - Accumulator-to-index and index-to-accumulator transfers are provided
// - Rotates go through carry in both directions
// - Branches on request pin level, high and low
// - Branches on interrupt mask clear and set
// - Direct address has high byte zero, low byte from operand
// - Inherent instructions are one byte with no address fetch
`timescale 1ns/100ps
`include "rbcd_consts.vh"

module rbcd_core
(
  input  wire        MCLK_I,        // Core clock, 10 MHz
  input  wire        SYS_RST_I,     // Async reset, active high
  input  wire [7:0]  MEM_RDATA_I,   // Read data, valid in the same cycle as rd
  input  wire        IRQ_N_I,       // External request pin, active low
  output reg  [15:0] MEM_ADDR_O,    // Memory address
  output reg         MEM_RD_O,      // Read strobe, one cycle
  output reg         MEM_WR_O,      // Write strobe, one cycle
  output reg  [7:0]  MEM_WDATA_O,   // Write data
  output reg  [15:0] PC_O,          // Program counter
  output reg  [7:0]  ACC_O,         // Accumulator
  output reg  [7:0]  IDX_O,         // Index register
  output reg  [7:0]  SP_O,          // Stack pointer, page zero
  output reg  [4:0]  CCR_O,         // H I N Z C
  output reg         OSC_STOP_O,    // Oscillator halted
  output reg         CLK_STOP_O,    // Core clock stopped (wait)
  output reg         IRQ_PIN_EN_O,  // Request pin armed to wake
  output reg         UNDEF_O        // Sticky undefined opcode seen
);

  localparam [3:0] S_FETCH = 4'h0;
  localparam [3:0] S_DEC   = 4'h1;
  localparam [3:0] S_OP1   = 4'h2;
  localparam [3:0] S_OP2   = 4'h3;
  localparam [3:0] S_RD    = 4'h4;
  localparam [3:0] S_REL   = 4'h5;
  localparam [3:0] S_PUSHL = 4'h6;
  localparam [3:0] S_PUSHH = 4'h7;
  localparam [3:0] S_POP1  = 4'h8;
  localparam [3:0] S_POP2  = 4'h9;
  localparam [3:0] S_HALT  = 4'hA;

  reg  [3:0]  state_r;
  reg  [7:0]  opc_r;
  reg  [7:0]  op1_r;
  reg  [15:0] tgt_r;
  reg         taken_r;
  reg         irq_meta_r;
  reg         irq_sync_r;

  wire [3:0]  grp = opc_r[7:4];
  wire [3:0]  sub = opc_r[3:0];
  wire [2:0]  bit_sel = opc_r[3:1];
  wire        pol_clr = opc_r[0];

  // Pin passes two flops before any decode reads it
  always @(posedge MCLK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      irq_meta_r <= 1'b1;
      irq_sync_r <= 1'b1;
    end
    else
    begin
      irq_meta_r <= IRQ_N_I;
      irq_sync_r <= irq_meta_r;
    end
  end

  // Modify unit: result in [7:0], new carry in [8]
  function [8:0] rmw_f;
    input [3:0] op;
    input [7:0] v;
    input       c;
    begin
      case (op)
        `RBCD_RMW_NEG: rmw_f = {(v != 8'h00), 8'h00 - v};
        `RBCD_RMW_COM: rmw_f = {1'b1, ~v};
        `RBCD_RMW_LSR: rmw_f = {v[0], 1'b0, v[7:1]};
        `RBCD_RMW_ROR: rmw_f = {v[0], c, v[7:1]};
        `RBCD_RMW_ASR: rmw_f = {v[0], v[7], v[7:1]};
        `RBCD_RMW_ASL: rmw_f = {v[7], v[6:0], 1'b0};
        `RBCD_RMW_ROL: rmw_f = {v[7], v[6:0], c};
        `RBCD_RMW_DEC: rmw_f = {c, v - 8'h01};
        `RBCD_RMW_INC: rmw_f = {c, v + 8'h01};
        `RBCD_RMW_CLR: rmw_f = {c, 8'h00};
        default:       rmw_f = {c, v};                 // Test passes value
      endcase
    end
  endfunction

  // Which low nibbles are defined modify operations
  function rmw_ok_f;
    input [3:0] op;
    begin
      case (op)
        `RBCD_RMW_NEG, `RBCD_RMW_COM, `RBCD_RMW_LSR, `RBCD_RMW_ROR,
        `RBCD_RMW_ASR, `RBCD_RMW_ASL, `RBCD_RMW_ROL, `RBCD_RMW_DEC,
        `RBCD_RMW_INC, `RBCD_RMW_TST, `RBCD_RMW_CLR: rmw_ok_f = 1'b1;
        default: rmw_ok_f = 1'b0;
      endcase
    end
  endfunction

  // Operand for modify: memory data or the register named by the group
  reg [7:0] rmw_in;
  always @*
  begin
    case (grp)
      `RBCD_GRP_RMW_ACC: rmw_in = ACC_O;
      `RBCD_GRP_RMW_IDX: rmw_in = IDX_O;
      default:           rmw_in = MEM_RDATA_I;
    endcase
  end

  wire [8:0] rmw_res = rmw_f(sub, rmw_in, CCR_O[`RBCD_CC_C]);
  wire       rmw_ok  = rmw_ok_f(sub);
  wire       is_tst  = (sub == `RBCD_RMW_TST);

  // Relative branch conditions; odd opcode inverts the even test
  reg br_base;
  always @*
  begin
    case (opc_r[3:1])
      3'h0: br_base = 1'b1;
      3'h1: br_base = ~(CCR_O[`RBCD_CC_C] | CCR_O[`RBCD_CC_Z]);
      3'h2: br_base = ~CCR_O[`RBCD_CC_C];
      3'h3: br_base = ~CCR_O[`RBCD_CC_Z];
      3'h4: br_base = ~CCR_O[`RBCD_CC_H];
      3'h5: br_base = ~CCR_O[`RBCD_CC_N];
      3'h6: br_base = ~CCR_O[`RBCD_CC_I];
      default: br_base = ~irq_sync_r;
    endcase
  end
  wire br_cond = br_base ^ opc_r[0];

  // Tested or modified bit of the page-zero byte just read
  wire       mem_bit = MEM_RDATA_I[bit_sel];
  wire [7:0] bit_mask = 8'h01 << bit_sel;

  // Offset byte sign-extended onto the already advanced PC
  wire [15:0] rel_tgt = PC_O + {{8{MEM_RDATA_I[7]}}, MEM_RDATA_I};

  // Main sequencer; each memory access is one strobe cycle
  always @(posedge MCLK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      state_r      <= S_FETCH;
      opc_r        <= 8'h00;
      op1_r        <= 8'h00;
      tgt_r        <= 16'h0000;
      taken_r      <= 1'b0;
      MEM_ADDR_O   <= 16'h0000;
      MEM_RD_O     <= 1'b0;
      MEM_WR_O     <= 1'b0;
      MEM_WDATA_O  <= 8'h00;
      PC_O         <= `RBCD_PC_RST;
      ACC_O        <= 8'h00;
      IDX_O        <= 8'h00;
      SP_O         <= `RBCD_SP_RST;
      CCR_O        <= `RBCD_CCR_RST;
      OSC_STOP_O   <= 1'b0;
      CLK_STOP_O   <= 1'b0;
      IRQ_PIN_EN_O <= 1'b0;
      UNDEF_O      <= 1'b0;
    end
    else
    begin
      MEM_RD_O <= 1'b0;
      MEM_WR_O <= 1'b0;
      case (state_r)
        S_FETCH:
        begin
          MEM_ADDR_O <= PC_O;
          MEM_RD_O   <= 1'b1;
          PC_O       <= PC_O + 16'h0001;
          state_r    <= S_DEC;
        end
        S_DEC:
        begin
          opc_r   <= MEM_RDATA_I;
          state_r <= S_OP1;
        end
        S_OP1:
        begin
          // Opcode is latched; decide on its group
          state_r <= S_FETCH;
          case (grp)
            `RBCD_GRP_BITBR, `RBCD_GRP_BITSC,
            `RBCD_GRP_BRANCH, `RBCD_GRP_RMW_DIR:
            begin
              MEM_ADDR_O <= PC_O;
              MEM_RD_O   <= 1'b1;
              PC_O       <= PC_O + 16'h0001;
              state_r    <= S_OP2;
              if (grp == `RBCD_GRP_RMW_DIR && !rmw_ok)
              begin
                MEM_RD_O <= 1'b0;
                PC_O     <= PC_O;
                UNDEF_O  <= 1'b1;
                state_r  <= S_FETCH;
              end
            end
            `RBCD_GRP_RMW_ACC, `RBCD_GRP_RMW_IDX:
            begin
              // One-byte register forms, no address fetch
              if (rmw_ok)
              begin
                if (!is_tst)
                begin
                  if (grp == `RBCD_GRP_RMW_ACC)
                    ACC_O <= rmw_res[7:0];
                  else
                    IDX_O <= rmw_res[7:0];
                end
                CCR_O[`RBCD_CC_N] <= rmw_res[7];
                CCR_O[`RBCD_CC_Z] <= (rmw_res[7:0] == 8'h00);
                CCR_O[`RBCD_CC_C] <= rmw_res[8];
              end
              else
                UNDEF_O <= 1'b1;
            end
            default:
            begin
              // Control and jump opcodes
              case (opc_r)
                `RBCD_OP_TAX: IDX_O <= ACC_O;
                `RBCD_OP_TXA: ACC_O <= IDX_O;
                `RBCD_OP_CLC: CCR_O[`RBCD_CC_C] <= 1'b0;
                `RBCD_OP_SEC: CCR_O[`RBCD_CC_C] <= 1'b1;
                `RBCD_OP_CLI: CCR_O[`RBCD_CC_I] <= 1'b0;
                `RBCD_OP_SEI: CCR_O[`RBCD_CC_I] <= 1'b1;
                `RBCD_OP_RSP: SP_O <= `RBCD_SP_RST;
                `RBCD_OP_NOP: CCR_O <= CCR_O;
                `RBCD_OP_STOP:
                begin
                  OSC_STOP_O        <= 1'b1;
                  IRQ_PIN_EN_O      <= 1'b1;
                  CCR_O[`RBCD_CC_I] <= 1'b0;
                  state_r           <= S_HALT;
                end
                `RBCD_OP_WAIT:
                begin
                  CLK_STOP_O        <= 1'b1;
                  CCR_O[`RBCD_CC_I] <= 1'b0;
                  state_r           <= S_HALT;
                end
                `RBCD_OP_RTS:
                begin
                  SP_O       <= SP_O + 8'h01;
                  MEM_ADDR_O <= {`RBCD_PAGE0_HI, SP_O + 8'h01};
                  MEM_RD_O   <= 1'b1;
                  state_r    <= S_POP1;
                end
                `RBCD_OP_JMP_DIR, `RBCD_OP_JSR_DIR,
                `RBCD_OP_JMP_EXT, `RBCD_OP_JSR_EXT:
                begin
                  // Address bytes only; A and X are untouched
                  MEM_ADDR_O <= PC_O;
                  MEM_RD_O   <= 1'b1;
                  PC_O       <= PC_O + 16'h0001;
                  state_r    <= S_OP2;
                end
                default: UNDEF_O <= 1'b1;
              endcase
            end
          endcase
        end
        S_OP2:
        begin
          // First operand byte has arrived
          op1_r   <= MEM_RDATA_I;
          state_r <= S_FETCH;
          case (grp)
            `RBCD_GRP_BRANCH:
            begin
              if (br_cond)
                PC_O <= rel_tgt;
            end
            `RBCD_GRP_BITBR, `RBCD_GRP_BITSC, `RBCD_GRP_RMW_DIR:
            begin
              MEM_ADDR_O <= {`RBCD_PAGE0_HI, MEM_RDATA_I};
              MEM_RD_O   <= 1'b1;
              state_r    <= S_RD;
            end
            default:
            begin
              if (opc_r == `RBCD_OP_JMP_EXT || opc_r == `RBCD_OP_JSR_EXT)
              begin
                // High address byte held, low byte still to come
                MEM_ADDR_O <= PC_O;
                MEM_RD_O   <= 1'b1;
                PC_O       <= PC_O + 16'h0001;
                state_r    <= S_REL;
              end
              else if (opc_r == `RBCD_OP_JMP_DIR)
                PC_O <= {`RBCD_PAGE0_HI, MEM_RDATA_I};
              else
              begin
                tgt_r   <= {`RBCD_PAGE0_HI, MEM_RDATA_I};
                state_r <= S_PUSHL;
              end
            end
          endcase
        end
        S_RD:
        begin
          // Page-zero operand byte is on the read bus
          state_r     <= S_FETCH;
          MEM_WDATA_O <= rmw_res[7:0];
          case (grp)
            `RBCD_GRP_BITBR:
            begin
              CCR_O[`RBCD_CC_C] <= mem_bit;
              taken_r    <= mem_bit ^ pol_clr;
              MEM_ADDR_O <= PC_O;
              MEM_RD_O   <= 1'b1;
              PC_O       <= PC_O + 16'h0001;
              state_r    <= S_REL;
            end
            `RBCD_GRP_BITSC:
            begin
              // Same address stays on the bus for the write
              MEM_WDATA_O <= pol_clr ? (MEM_RDATA_I & ~bit_mask)
                                     : (MEM_RDATA_I | bit_mask);
              MEM_WR_O    <= 1'b1;
            end
            default:
            begin
              MEM_WR_O          <= !is_tst;
              CCR_O[`RBCD_CC_N] <= rmw_res[7];
              CCR_O[`RBCD_CC_Z] <= (rmw_res[7:0] == 8'h00);
              CCR_O[`RBCD_CC_C] <= rmw_res[8];
            end
          endcase
        end
        S_REL:
        begin
          // Offset byte for bit branch, or low byte of extended jump
          state_r <= S_FETCH;
          if (grp == `RBCD_GRP_BITBR)
          begin
            if (taken_r)
              PC_O <= rel_tgt;
          end
          else if (opc_r == `RBCD_OP_JMP_EXT)
            PC_O <= {op1_r, MEM_RDATA_I};
          else
          begin
            tgt_r   <= {op1_r, MEM_RDATA_I};
            state_r <= S_PUSHL;
          end
        end
        S_PUSHL:
        begin
          // Return address low byte goes on the stack first
          MEM_ADDR_O  <= {`RBCD_PAGE0_HI, SP_O};
          MEM_WDATA_O <= PC_O[7:0];
          MEM_WR_O    <= 1'b1;
          SP_O        <= SP_O - 8'h01;
          state_r     <= S_PUSHH;
        end
        S_PUSHH:
        begin
          MEM_ADDR_O  <= {`RBCD_PAGE0_HI, SP_O};
          MEM_WDATA_O <= PC_O[15:8];
          MEM_WR_O    <= 1'b1;
          SP_O        <= SP_O - 8'h01;
          PC_O        <= tgt_r;
          state_r     <= S_FETCH;
        end
        S_POP1:
        begin
          PC_O[15:8] <= MEM_RDATA_I;
          SP_O       <= SP_O + 8'h01;
          MEM_ADDR_O <= {`RBCD_PAGE0_HI, SP_O + 8'h01};
          MEM_RD_O   <= 1'b1;
          state_r    <= S_POP2;
        end
        S_POP2:
        begin
          PC_O[7:0] <= MEM_RDATA_I;
          state_r   <= S_FETCH;
        end
        S_HALT:
        begin
          // Only a low level on the request pin resumes; no vector taken
          if (!irq_sync_r)
          begin
            OSC_STOP_O   <= 1'b0;
            CLK_STOP_O   <= 1'b0;
            IRQ_PIN_EN_O <= 1'b0;
            state_r      <= S_FETCH;
          end
        end
        default: state_r <= S_FETCH;
      endcase
    end
  end

endmodule // rbcd_core

/* verification/rbcd_core_monitor.sv */
// Port-level checker for the branch and modify decoder
`timescale 1ns/100ps
`include "rbcd_consts.vh"

module rbcd_core_monitor
(
  input wire        MCLK_I,       // Core clock
  input wire        SYS_RST_I,    // Async reset, high
  input wire [7:0]  MEM_RDATA_I,  // Read data
  input wire        IRQ_N_I,      // Request pin
  input wire [15:0] MEM_ADDR_O,   // Address
  input wire        MEM_RD_O,     // Read strobe
  input wire        MEM_WR_O,     // Write strobe
  input wire [7:0]  MEM_WDATA_O,  // Write data
  input wire [15:0] PC_O,         // Program counter
  input wire [7:0]  ACC_O,        // Accumulator
  input wire [7:0]  IDX_O,        // Index register
  input wire [7:0]  SP_O,         // Stack pointer
  input wire [4:0]  CCR_O,        // Flags
  input wire        OSC_STOP_O,   // Stop state
  input wire        CLK_STOP_O,   // Wait state
  input wire        IRQ_PIN_EN_O, // Pin armed
  input wire        UNDEF_O       // Undefined seen
);
  // Opcode fetch guess: read just behind PC; operands may alias it
  wire fetch = MEM_RD_O && (MEM_ADDR_O + 16'h0001 == PC_O);

  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (SYS_RST_I);

  a_strobe_excl: assert property (
    !(MEM_RD_O && MEM_WR_O)) else $error("Both strobes high");
  a_rmw_write_back: assert property (
    fetch && MEM_RDATA_I == 8'h3C |-> ##2 MEM_RD_O ##1
    MEM_ADDR_O == {8'h00, $past(MEM_RDATA_I)} ##1 MEM_WR_O &&
    $stable(MEM_ADDR_O) && MEM_WDATA_O == $past(MEM_RDATA_I) + 8'h01)
    else $error("Increment not written back in place");
  a_test_no_write: assert property (
    fetch && MEM_RDATA_I == 8'h3D |-> !MEM_WR_O [*6])
    else $error("Test opcode wrote memory");
  a_branch_not_taken: assert property (
    fetch && MEM_RDATA_I == 8'h2C && CCR_O[`RBCD_CC_I] |-> ##3
    PC_O == $past(MEM_ADDR_O, 3) + 16'h0002)
    else $error("False branch moved PC");
  a_branch_taken: assert property (
    fetch && MEM_RDATA_I == 8'h2D && CCR_O[`RBCD_CC_I] |-> ##3
    PC_O == $past(MEM_ADDR_O, 3) + 16'h0002 +
    {{8{$past(MEM_RDATA_I[7])}}, $past(MEM_RDATA_I)})
    else $error("Taken branch target wrong");
  // A true opcode read is followed by a quiet decode cycle, then the
  // address read; an extended jump high address byte of 01 is followed by a read at once
  a_bit_to_carry: assert property (
    fetch && MEM_RDATA_I[7:1] == 7'h00 ##1 !MEM_RD_O ##1 MEM_RD_O |->
    ##1 MEM_RD_O && MEM_ADDR_O[15:8] == 8'h00 ##1
    CCR_O[`RBCD_CC_C] == $past(MEM_RDATA_I[0]))
    else $error("Tested bit not copied to carry");
  a_page_zero_wr: assert property (
    MEM_WR_O |-> MEM_ADDR_O[15:8] == 8'h00)
    else $error("Write outside page zero");
  a_inherent_xfer: assert property (
    fetch && MEM_RDATA_I == 8'h97 |-> ##1 !MEM_RD_O ##1 !MEM_RD_O &&
    IDX_O == ACC_O && PC_O == $past(MEM_ADDR_O, 2) + 16'h0001)
    else $error("Transfer not one byte inherent");
  a_jump_direct: assert property (
    fetch && MEM_RDATA_I == 8'hBC |-> ##2 MEM_RD_O ##1
    PC_O == {8'h00, $past(MEM_RDATA_I)} && !MEM_WR_O)
    else $error("Direct jump target wrong");
  a_stop_arms_pin: assert property (
    fetch && MEM_RDATA_I == 8'h8E |-> ##2 OSC_STOP_O && IRQ_PIN_EN_O)
    else $error("Stop did not halt and arm pin");
  a_wait_clears_i: assert property (
    fetch && MEM_RDATA_I == 8'h8F |-> ##2 CLK_STOP_O &&
    !CCR_O[`RBCD_CC_I]) else $error("Wait did not halt or clear mask");

  c_write: cover property (MEM_WR_O);
  c_wait: cover property ($rose(CLK_STOP_O));
  c_stop: cover property ($rose(OSC_STOP_O));
endmodule // rbcd_core_monitor

bind rbcd_core rbcd_core_monitor i_mon (.MCLK_I(MCLK_I),
  .SYS_RST_I(SYS_RST_I), .MEM_RDATA_I(MEM_RDATA_I), .IRQ_N_I(IRQ_N_I),
  .MEM_ADDR_O(MEM_ADDR_O), .MEM_RD_O(MEM_RD_O), .MEM_WR_O(MEM_WR_O),
  .MEM_WDATA_O(MEM_WDATA_O), .PC_O(PC_O), .ACC_O(ACC_O), .IDX_O(IDX_O),
  .SP_O(SP_O), .CCR_O(CCR_O), .OSC_STOP_O(OSC_STOP_O),
  .CLK_STOP_O(CLK_STOP_O), .IRQ_PIN_EN_O(IRQ_PIN_EN_O), .UNDEF_O(UNDEF_O));

/* verification/rbcd_mem.sv */
// Program and data memory model with asynchronous read
`timescale 1ns/100ps

module rbcd_mem
(
  input  wire        mclk_i,   // Core clock
  input  wire [15:0] addr_i,   // Address from core
  input  wire        rd_i,     // Read strobe
  input  wire        wr_i,     // Write strobe
  input  wire [7:0]  wdata_i,  // Write data
  output wire [7:0]  rdata_o   // Read data
);
  reg [7:0] mem [0:65535];
  reg [7:0] last_r;

  // Idle bus shows the inverse of the last byte, so stale data cannot pass
  assign rdata_o = rd_i ? mem[addr_i] : ~last_r;

  // Writes land at the edge closing the strobe cycle
  always @(posedge mclk_i)
  begin
    if (wr_i)
      mem[addr_i] <= wdata_i;
    if (rd_i)
      last_r <= mem[addr_i];
  end

  initial last_r = 8'h00;
endmodule // rbcd_mem

/* verification/tb.sv */
// Self-checking testbench running small programs on the decoder
`timescale 1ns/100ps

module tb;
  reg         MCLK_I;
  reg         SYS_RST_I;
  reg         IRQ_N_I;
  wire [7:0]  MEM_RDATA_I;
  wire [15:0] MEM_ADDR_O;
  wire        MEM_RD_O;
  wire        MEM_WR_O;
  wire [7:0]  MEM_WDATA_O;
  wire [15:0] PC_O;
  wire [7:0]  ACC_O;
  wire [7:0]  IDX_O;
  wire [7:0]  SP_O;
  wire [4:0]  CCR_O;
  wire        OSC_STOP_O;
  wire        CLK_STOP_O;
  wire        IRQ_PIN_EN_O;
  wire        UNDEF_O;
  integer     fails;
  integer     total_checks;
  integer     cyc;
  integer     i;

  rbcd_core i_rbcd_core (.MCLK_I(MCLK_I), .SYS_RST_I(SYS_RST_I),
    .MEM_RDATA_I(MEM_RDATA_I), .IRQ_N_I(IRQ_N_I), .MEM_ADDR_O(MEM_ADDR_O),
    .MEM_RD_O(MEM_RD_O), .MEM_WR_O(MEM_WR_O), .MEM_WDATA_O(MEM_WDATA_O),
    .PC_O(PC_O), .ACC_O(ACC_O), .IDX_O(IDX_O), .SP_O(SP_O), .CCR_O(CCR_O),
    .OSC_STOP_O(OSC_STOP_O), .CLK_STOP_O(CLK_STOP_O),
    .IRQ_PIN_EN_O(IRQ_PIN_EN_O), .UNDEF_O(UNDEF_O));

  rbcd_mem i_rbcd_mem (.mclk_i(MCLK_I), .addr_i(MEM_ADDR_O),
    .rd_i(MEM_RD_O), .wr_i(MEM_WR_O), .wdata_i(MEM_WDATA_O),
    .rdata_o(MEM_RDATA_I));

  // Clock, 100 ns period
  initial MCLK_I = 1'b0;
  always #50 MCLK_I = ~MCLK_I;

  // Hang guard, far above the few hundred cycles the tests need
  always @(posedge MCLK_I)
  begin
    cyc = cyc + 1;
    if (cyc == 3000)
    begin
      fails = fails + 1;
      close_out;
    end
  end

  task chk(input [15:0] got, input [15:0] exp);
    total_checks = total_checks + 1;
    if (got !== exp)
    begin
      fails = fails + 1;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // PC parked in a two-byte self loop starting at lo
  task chk_pc(input [15:0] lo);
    chk((PC_O >= lo && PC_O <= lo + 16'h0002) ? lo : PC_O, lo);
  endtask

  task put4(input [15:0] a, input [31:0] w);
    i_rbcd_mem.mem[a] = w[31:24];
    i_rbcd_mem.mem[a + 16'h0001] = w[23:16];
    i_rbcd_mem.mem[a + 16'h0002] = w[15:8];
    i_rbcd_mem.mem[a + 16'h0003] = w[7:0];
  endtask

  // Reset held while memory is filled with no-ops and a program loaded
  task begin_test;
    @(posedge MCLK_I);
    SYS_RST_I <= 1'b1;
    IRQ_N_I <= 1'b1;
    for (i = 0; i < 65536; i = i + 1)
      i_rbcd_mem.mem[i] = 8'h9D;
  endtask

  task go(input integer n);
    repeat (2) @(posedge MCLK_I);
    SYS_RST_I <= 1'b0;
    repeat (n) @(posedge MCLK_I);
    #10;
  endtask

  task irq_wake;
    @(posedge MCLK_I);
    IRQ_N_I <= 1'b0;
    for (i = 0; i < 20 && (OSC_STOP_O | CLK_STOP_O) !== 1'b0; i = i + 1)
      @(posedge MCLK_I);
    repeat (20) @(posedge MCLK_I);
    #10;
  endtask

  task t_modify;
    begin_test;
    put4(16'h0000, 32'h3C103D11);
    put4(16'h0004, 32'h33123013);
    put4(16'h0008, 32'h3A1420FE);
    put4(16'h0010, 32'h7F000F01);
    put4(16'h0014, 32'h009D9D9D);
    go(40);
    chk({8'h00, i_rbcd_mem.mem[16'h0010]}, 16'h0080);
    chk({8'h00, i_rbcd_mem.mem[16'h0011]}, 16'h0000);
    chk({8'h00, i_rbcd_mem.mem[16'h0012]}, 16'h00F0);
    chk({8'h00, i_rbcd_mem.mem[16'h0013]}, 16'h00FF);
    chk({8'h00, i_rbcd_mem.mem[16'h0014]}, 16'h00FF);
    chk({13'h0000, CCR_O[2:0]}, 16'h0005);
    $display("test modify done");
  endtask

  task t_rotate;
    begin_test;
    put4(16'h0000, 32'h9946494C);
    put4(16'h0004, 32'h974C9F20);
    put4(16'h0008, 32'hFE9D9D9D);
    go(40);
    chk({8'h00, ACC_O}, 16'h0001);
    chk({8'h00, IDX_O}, 16'h0001);
    chk({15'h0000, CCR_O[0]}, 16'h0001);
    $display("test rotate done");
  endtask

  task t_bits;
    begin_test;
    put4(16'h0000, 32'h10201F20);
    put4(16'h0004, 32'h00200220);
    put4(16'h0008, 32'hFE012002);
    put4(16'h000C, 32'h20FE9D9D);
    put4(16'h0020, 32'h809D9D9D);
    go(50);
    chk({8'h00, i_rbcd_mem.mem[16'h0020]}, 16'h0001);
    chk({15'h0000, CCR_O[0]}, 16'h0001);
    chk_pc(16'h000C);
    $display("test bits done");
  endtask

  task t_branch;
    begin_test;
    put4(16'h0000, 32'h2C7F2D7F);
    put4(16'h0004, 32'h9D9D9D9A);
    put4(16'h0008, 32'h2CFE9D9D);
    put4(16'h0083, 32'h2E7F2F80);
    go(40);
    chk({15'h0000, CCR_O[3]}, 16'h0000);
    chk_pc(16'h0008);
    $display("test branch done");
  endtask

  task t_wait;
    begin_test;
    put4(16'h0000, 32'hCD01102E);
    put4(16'h0004, 32'hFE9D9D9D);
    put4(16'h0110, 32'h8F819D9D);
    go(30);
    chk({15'h0000, CLK_STOP_O}, 16'h0001);
    chk({15'h0000, CCR_O[3]}, 16'h0000);
    chk({8'h00, SP_O}, 16'h00FD);
    chk({i_rbcd_mem.mem[16'h00FE], i_rbcd_mem.mem[16'h00FF]}, 16'h0003);
    irq_wake;
    chk({15'h0000, CLK_STOP_O}, 16'h0000);
    chk_pc(16'h0003);
    chk({8'h00, SP_O}, 16'h00FF);
    $display("test wait done");
  endtask

  task t_stop;
    begin_test;
    put4(16'h0000, 32'h428EBC40);
    put4(16'h0040, 32'h20FE9D9D);
    go(30);
    chk({15'h0000, UNDEF_O}, 16'h0001);
    chk({14'h0000, OSC_STOP_O, IRQ_PIN_EN_O}, 16'h0003);
    irq_wake;
    chk({15'h0000, OSC_STOP_O}, 16'h0000);
    chk_pc(16'h0040);
    $display("test stop done");
  endtask

  task close_out;
    $display("Checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    SYS_RST_I = 1'b1;
    IRQ_N_I = 1'b1;
    fails = 0;
    total_checks = 0;
    cyc = 0;
    t_modify;
    t_rotate;
    t_bits;
    t_branch;
    t_wait;
    t_stop;
    close_out;
  end
endmodule // tb
